//--- common/ldcr_defs.svh
// Constants for the load-current, frequency and unlock register group.
// Assumes an upstream serial slave turns host transfers into the
// single-cycle register strobes used by the register block.
//
// Overview of operation
// - The upper readout register shows result bit 8 in bit 0, others zero.
// - The lower readout register shows result bits 7-0 at 20 mA per count.
// - Bit 2 of the frequency register is the read-only step-up field.
// - Bits 1-0 of the frequency register are the shared step-down field.
// - Bits 1-0 of the current-limit register are writable limit codes.
// - Bit 1 of the correction status flags uncorrected double errors.
// - Bit 0 of the correction status flags corrected single errors.
// - Writing 0x87, 0x65, 0x1B to the code register clears the lock flag.
// - Any other code write, or a watchdog lock write of 1, re-locks.
// - Reading the code register always returns zero.
// - While the watchdog lock bit is set the sequence is ignored.
// - A converter-select write starts a measurement, bit 0 picks it.
// - The permit bit takes 1 only while both lock bits are zero.
// - The lock flag is read-only and resets to 1, meaning locked.
`ifndef LDCR_DEFS_SVH
`define LDCR_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define LDCR_OFF_LOAD_HIGH   8'h2F
`define LDCR_OFF_LOAD_LOW    8'h30
`define LDCR_OFF_FREQ        8'h31
`define LDCR_OFF_ILIM        8'h32
`define LDCR_OFF_CORR_STAT   8'h33
`define LDCR_OFF_GUARD_CODE  8'h34

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define LDCR_FREQ_UP_BIT     2
`define LDCR_DOUBLE_ERR_BIT  1
`define LDCR_SINGLE_ERR_BIT  0
`define LDCR_RST_BYTE        8'h00
`define LDCR_RST_RESULT      9'h000
`define LDCR_RST_LOCK        1'b1

// ----------------------------------------------------------------
// Unlock code sequence
// ----------------------------------------------------------------
`define LDCR_CODE_FIRST      8'h87
`define LDCR_CODE_SECOND     8'h65
`define LDCR_CODE_THIRD      8'h1B

`endif

//--- common/ldcr_pkg.sv
// Types for the load-current, frequency and unlock register group.
// Assumes the constants header is included by each user.
package ldcr_pkg;
   // Progress through the three-write unlock sequence
   typedef enum logic [1:0] {
      LDCR_SEQ_IDLE,
      LDCR_SEQ_GOT1,
      LDCR_SEQ_GOT2
   } ldcr_seq_t;

   typedef logic [7:0] ldcr_byte_t;
endpackage : ldcr_pkg

//--- common/ldcr_if.sv
// Carrier between the register block and the unlock guard.
// Assumes both ends share the one device clock.
`timescale 1ns/1ps
`default_nettype none
interface ldcr_guard_if;
   logic       code_wr;      // Write strobe to the code register
   logic [7:0] code;         // Written code byte
   logic       wdog_lock;      // Watchdog lock bit level
   logic       wdog_lock_set;  // Watchdog lock bit written to 1
   logic       lock_flag;    // 1 = permit bit locked

   modport ctrl  (output code_wr, code, wdog_lock, wdog_lock_set,
                  input  lock_flag);
   modport guard (input  code_wr, code, wdog_lock, wdog_lock_set,
                  output lock_flag);
endinterface : ldcr_guard_if
`default_nettype wire

//--- src/ldcr_unlock.sv
// Unlock-code guard for the watchdog-disable permit bit.
// Assumes code writes arrive as single-cycle strobes on the device clock.
`include "ldcr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ldcr_unlock (
   input  wire logic   clk,
   input  wire logic   rst_n,
   ldcr_guard_if.guard gi
);
   import ldcr_pkg::*;

   ldcr_seq_t seq_reg;
   logic      lock_reg;
   logic      seq_ok;     // Write is the correct next code

   assign gi.lock_flag = lock_reg;

   // ----------------------------------------------------------------
   // Sequence tracking
   // ----------------------------------------------------------------
   // Code-register writes step the sequence, and the watchdog lock bit or a
   // lock write returns it to idle; other traffic leaves it where it was
   always_comb begin
      seq_ok = 1'b0;
      case (seq_reg)
         LDCR_SEQ_IDLE: seq_ok = (gi.code == `LDCR_CODE_FIRST);
         LDCR_SEQ_GOT1: seq_ok = (gi.code == `LDCR_CODE_SECOND);
         LDCR_SEQ_GOT2: seq_ok = (gi.code == `LDCR_CODE_THIRD);
         default:       seq_ok = 1'b0;
      endcase
   end

   // Advance on a good code, fall back on anything else
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seq_reg <= LDCR_SEQ_IDLE;
      end else if (gi.wdog_lock || gi.wdog_lock_set) begin
         seq_reg <= LDCR_SEQ_IDLE;
      end else if (gi.code_wr) begin
         case (seq_reg)
            LDCR_SEQ_IDLE: seq_reg <= seq_ok ? LDCR_SEQ_GOT1
                                             : LDCR_SEQ_IDLE;
            LDCR_SEQ_GOT1: seq_reg <= seq_ok ? LDCR_SEQ_GOT2
                                             : LDCR_SEQ_IDLE;
            default:       seq_reg <= LDCR_SEQ_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Lock flag
   // ----------------------------------------------------------------
   // Locking wins over unlocking so a stray write never opens the bit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_reg <= `LDCR_RST_LOCK;
      end else if (gi.wdog_lock || gi.wdog_lock_set) begin
         lock_reg <= 1'b1;
      end else if (gi.code_wr) begin
         lock_reg <= !(seq_reg == LDCR_SEQ_GOT2 && seq_ok);
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_full_unlock: assert property (
      (seq_reg == LDCR_SEQ_GOT2 && gi.code_wr &&
       gi.code == `LDCR_CODE_THIRD && !gi.wdog_lock && !gi.wdog_lock_set)
      |=> !lock_reg)
      else $error("third code did not unlock");
   a_unlock_cause: assert property (
      $fell(lock_reg) |-> $past(gi.code_wr) &&
      $past(gi.code) == `LDCR_CODE_THIRD && $past(seq_reg) == LDCR_SEQ_GOT2)
      else $error("unlock without full sequence");
   a_stray_relock: assert property (
      (gi.code_wr && !(seq_reg == LDCR_SEQ_GOT2 && seq_ok)) |=> lock_reg)
      else $error("stray code write left bit unlocked");
   a_lockset_relock: assert property (
      gi.wdog_lock_set |=> lock_reg && seq_reg == LDCR_SEQ_IDLE)
      else $error("watchdog lock write did not re-lock");
   a_wdlock_holds: assert property (
      gi.wdog_lock [*2] |-> lock_reg)
      else $error("unlocked while watchdog lock set");
   c_unlock: cover property (
      gi.code_wr ##2 gi.code_wr ##2 gi.code_wr ##1 !lock_reg);
   c_relock: cover property (!lock_reg ##1 gi.code_wr ##1 lock_reg);
endmodule : ldcr_unlock
`default_nettype wire

//--- src/ldcr_regs.sv
// Register group: load-current readout, switching-frequency selections,
// step-up current limit, one-time-memory correction status and the
// unlock code guarding the watchdog-disable permit bit.
// Assumes the serial slave in front supplies one-cycle read and write
// strobes with a byte address, and that one-time-memory values are valid
// when otp_load pulses.
`include "ldcr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ldcr_regs (
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Register access port
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire ldcr_pkg::ldcr_byte_t reg_wdata,
   output ldcr_pkg::ldcr_byte_t      reg_rdata,
   output logic             reg_rvalid,
   // One-time memory defaults and correction status
   input  wire logic        otp_load,
   input  wire logic        otp_step_up_freq,
   input  wire logic [1:0]  otp_step_down_freq,
   input  wire logic [1:0]  otp_current_limit,
   input  wire logic        otp_double_error,
   input  wire logic        otp_single_error,
   // Measurement path
   input  wire logic        sel_wr,
   input  wire logic [1:0]  sel_value,
   input  wire logic        meas_done,
   input  wire logic [8:0]  meas_value,
   output logic             meas_start,
   output logic             meas_conv,
   // Watchdog-disable control
   input  wire logic        watchdog_lock_bit,
   input  wire logic        watchdog_lock_set,
   input  wire logic        permit_wr,
   input  wire logic        permit_wdata,
   output logic             pin_control_lock_flag,
   output logic             pin_disable_permit_bit,
   // Settings seen by the converters
   output logic             step_up_freq_field,
   output logic [1:0]       step_down_freq_field,
   output logic [1:0]       step_up_current_limit_field
);
   import ldcr_pkg::*;

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [8:0] result_reg;      // Latest nine-bit load current
   logic [4:0] freq_rsvd_reg;   // Writable reserved bits 7-3
   logic [5:0] ilim_rsvd_reg;   // Writable reserved bits 7-2
   logic       double_err_reg;  // Uncorrected double error seen
   logic       single_err_reg;  // Corrected single error seen
   ldcr_byte_t rdata_next;
   logic       code_wr;

   ldcr_guard_if gif ();

   // ----------------------------------------------------------------
   // Unlock guard
   // ----------------------------------------------------------------
   assign code_wr         = reg_wr && (reg_addr == `LDCR_OFF_GUARD_CODE);
   assign gif.code_wr     = code_wr;
   assign gif.code        = reg_wdata;
   assign gif.wdog_lock     = watchdog_lock_bit;
   assign gif.wdog_lock_set = watchdog_lock_set;

   ldcr_unlock ldcr_unlock_inst (
      .clk   (clk),
      .rst_n (rst_n),
      .gi    (gif.guard)
   );

   // Lock flag leaves the guard straight from its flop
   assign pin_control_lock_flag = gif.lock_flag;

   // ----------------------------------------------------------------
   // Measurement start
   // ----------------------------------------------------------------
   // Select values 0 and 2 mean converter zero, 1 and 3 converter one,
   // so only bit 0 matters
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meas_start <= 1'b0;
         meas_conv  <= 1'b0;
      end else begin
         meas_start <= sel_wr;
         if (sel_wr) begin
            meas_conv <= sel_value[0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Load-current result
   // ----------------------------------------------------------------
   // All nine bits load in one edge, so a read of either half never
   // sees a mix of two measurements taken at different times
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         result_reg <= `LDCR_RST_RESULT;
      end else if (meas_done) begin
         result_reg <= meas_value;
      end
   end

   // ----------------------------------------------------------------
   // One-time memory images
   // ----------------------------------------------------------------
   // Frequency fields and correction flags are read-only copies
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         step_up_freq_field   <= 1'b0;
         step_down_freq_field <= 2'h0;
         double_err_reg       <= 1'b0;
         single_err_reg       <= 1'b0;
      end else if (otp_load) begin
         step_up_freq_field   <= otp_step_up_freq;
         step_down_freq_field <= otp_step_down_freq;
         double_err_reg       <= otp_double_error;
         single_err_reg       <= otp_single_error;
      end
   end

   // ----------------------------------------------------------------
   // Writable fields
   // ----------------------------------------------------------------
   // A host write in the same cycle as the memory load takes priority,
   // since it is the later intent
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         step_up_current_limit_field <= 2'h0;
         ilim_rsvd_reg               <= 6'h00;
      end else if (reg_wr && reg_addr == `LDCR_OFF_ILIM) begin
         step_up_current_limit_field <= reg_wdata[1:0];
         ilim_rsvd_reg               <= reg_wdata[7:2];
      end else if (otp_load) begin
         step_up_current_limit_field <= otp_current_limit;
      end
   end

   // Reserved bits above the frequency fields store what is written
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         freq_rsvd_reg <= 5'h00;
      end else if (reg_wr && reg_addr == `LDCR_OFF_FREQ) begin
         freq_rsvd_reg <= reg_wdata[7:3];
      end
   end

   // ----------------------------------------------------------------
   // Watchdog-disable permit bit
   // ----------------------------------------------------------------
   // Frozen while locked; once open a 1 still needs the watchdog lock
   // bit low, a 0 is always taken
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_disable_permit_bit <= 1'b0;
      end else if (permit_wr && !gif.lock_flag) begin
         if (!permit_wdata || !watchdog_lock_bit) begin
            pin_disable_permit_bit <= permit_wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   // Unmapped addresses read as zero
   always_comb begin
      rdata_next = `LDCR_RST_BYTE;
      case (reg_addr)
         `LDCR_OFF_LOAD_HIGH: rdata_next = {7'h00, result_reg[8]};
         `LDCR_OFF_LOAD_LOW:  rdata_next = result_reg[7:0];
         `LDCR_OFF_FREQ:      rdata_next = {freq_rsvd_reg,
                                            step_up_freq_field,
                                            step_down_freq_field};
         `LDCR_OFF_ILIM:      rdata_next = {ilim_rsvd_reg,
                                        step_up_current_limit_field};
         `LDCR_OFF_CORR_STAT: rdata_next = {6'h00, double_err_reg,
                                            single_err_reg};
         `LDCR_OFF_GUARD_CODE: rdata_next = `LDCR_RST_BYTE;
         default:             rdata_next = `LDCR_RST_BYTE;
      endcase
   end

   // Answer one cycle after the read strobe, held until the next read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata  <= `LDCR_RST_BYTE;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= rdata_next;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_high_readout: assert property (
      (reg_rd && reg_addr == `LDCR_OFF_LOAD_HIGH && !meas_done)
      |=> reg_rvalid && reg_rdata == {7'h00, result_reg[8]})
      else $error("upper readout wrong");
   a_low_readout: assert property (
      (reg_rd && reg_addr == `LDCR_OFF_LOAD_LOW)
      |=> reg_rvalid && reg_rdata == $past(result_reg[7:0]))
      else $error("lower readout wrong");
   a_freq_readout: assert property (
      (reg_rd && reg_addr == `LDCR_OFF_FREQ)
      |=> reg_rdata[2:0] ==
          $past({step_up_freq_field, step_down_freq_field}))
      else $error("frequency fields misread");
   a_ilim_write: assert property (
      (reg_wr && reg_addr == `LDCR_OFF_ILIM) ##1
      (!otp_load && !reg_wr) ##1 (reg_rd && reg_addr == `LDCR_OFF_ILIM)
      |=> reg_rdata[1:0] == $past(reg_wdata[1:0], 3))
      else $error("current limit not held");
   a_ecc_flags: assert property (
      otp_load |=> double_err_reg == $past(otp_double_error) &&
                   single_err_reg == $past(otp_single_error))
      else $error("correction flags not captured");
   a_code_reads_zero: assert property (
      (reg_rd && reg_addr == `LDCR_OFF_GUARD_CODE)
      |=> reg_rvalid && reg_rdata == 8'h00)
      else $error("code register read nonzero");
   a_meas_start: assert property (
      sel_wr |=> meas_start && meas_conv == $past(sel_value[0]))
      else $error("measurement start wrong");
   a_permit_guard: assert property (
      $rose(pin_disable_permit_bit)
      |-> $past(!gif.lock_flag && !watchdog_lock_bit && permit_wr))
      else $error("permit bit set while locked");
   a_result_atomic: assert property (
      !meas_done |=> $stable(result_reg))
      else $error("result changed without completion");
   c_meas: cover property (sel_wr ##[1:50] meas_done);
   c_read_load: cover property (
      meas_done ##2 (reg_rd && reg_addr == `LDCR_OFF_LOAD_HIGH));
   c_permit: cover property ($rose(pin_disable_permit_bit));
endmodule : ldcr_regs
`default_nettype wire

//--- dv/ldcr_host.sv
// Host-side model: the serial slave's decoded register strobes.
// Assumes one device clock; accesses are issued one after another.
`include "ldcr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ldcr_host (
   input  wire logic       clk,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata
);
   // ----------------------------------------------------------------
   // Bus tasks
   // ----------------------------------------------------------------
   // Idle bus at time zero
   initial begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'hFF;
      reg_wdata = 8'h00;
   end

   // One write, released after its taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;  // Released lines must not keep the old value
      reg_wdata <= ~d;
   endtask : wr

   // One read; the bench collects the answer
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
   endtask : rd

   // Three code writes in consecutive transfers to the code register
   task automatic unlock();
      wr(`LDCR_OFF_GUARD_CODE, `LDCR_CODE_FIRST);
      wr(`LDCR_OFF_GUARD_CODE, `LDCR_CODE_SECOND);
      wr(`LDCR_OFF_GUARD_CODE, `LDCR_CODE_THIRD);
   endtask : unlock
endmodule : ldcr_host
`default_nettype wire

//--- dv/load_current_freq_wd_unlock_regs_bench.sv
// Self-checking bench for the load-current and unlock register group.
// Assumes the host model drives the register strobes.
`include "ldcr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module load_current_freq_wd_unlock_regs_bench;
   import ldcr_pkg::*;
   logic clk, rst_n, reg_wr, reg_rd, reg_rvalid, otp_load, otp_up;
   logic otp_dbl, otp_sgl, sel_wr, meas_done, meas_start, meas_conv;
   logic wd_bit, wd_set, permit_wr, permit_wdata, lock_flag, permit;
   logic       up_f;
   logic [1:0] otp_down, otp_lim, sel_value, down_f, lim_f;
   logic [7:0] reg_addr;
   logic [8:0] meas_value;
   logic [31:0] r;
   ldcr_byte_t reg_wdata, reg_rdata;
   ldcr_byte_t exp_q[$];
   int         mismatches = 0;
   int         n_tests = 0;

   ldcr_host ldcr_host_inst (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata));

   ldcr_regs ldcr_regs_inst (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .otp_load(otp_load), .otp_step_up_freq(otp_up),
      .otp_step_down_freq(otp_down), .otp_current_limit(otp_lim),
      .otp_double_error(otp_dbl), .otp_single_error(otp_sgl),
      .sel_wr(sel_wr), .sel_value(sel_value), .meas_done(meas_done),
      .meas_value(meas_value), .meas_start(meas_start),
      .meas_conv(meas_conv), .watchdog_lock_bit(wd_bit),
      .watchdog_lock_set(wd_set), .permit_wr(permit_wr),
      .permit_wdata(permit_wdata), .pin_control_lock_flag(lock_flag),
      .pin_disable_permit_bit(permit), .step_up_freq_field(up_f),
      .step_down_freq_field(down_f), .step_up_current_limit_field(lim_f));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic check(input string nm, input logic [8:0] seen,
                        input logic [8:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : check

   task automatic finish_test();
      $display("Checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : finish_test

   // Note the expected byte, then let the host read
   task automatic rd(input logic [7:0] a, input ldcr_byte_t e);
      exp_q.push_back(e);
      ldcr_host_inst.rd(a);
   endtask : rd

   // Let the edge after a write land before looking at levels
   task automatic settle();
      @(posedge clk);
      #1;
   endtask : settle

   task automatic permit_write(input logic v);
      @(posedge clk);
      permit_wr    <= 1'b1;
      permit_wdata <= v;
      @(posedge clk);
      permit_wr    <= 1'b0;
      settle();
   endtask : permit_write

   // ----------------------------------------------------------------
   // Clock, read scoreboard and hang guard
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Each read answer is matched against the oldest note
   always @(posedge clk) begin
      if (reg_rvalid === 1'b1) begin
         if (exp_q.size() == 0)
            check("spare_rvalid", 9'h001, 9'h000);
         else
            check("reg_rdata", reg_rdata, exp_q.pop_front());
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      finish_test();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {rst_n, otp_load, otp_up, otp_down, otp_lim, otp_dbl} = '0;
      {otp_sgl, sel_wr, sel_value, meas_done, meas_value} = '0;
      {wd_bit, wd_set, permit_wr, permit_wdata} = '0;
      r = 32'hD633;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      check("lock_flag", lock_flag, 1'b1);
      // Every mapped place and one unmapped place read zero after reset
      for (int a = 8'h2F; a <= 8'h35; a++)
         rd(a[7:0], 8'h00);
      // Defaults from one-time memory, every step-down code once
      for (int i = 0; i < 4; i++) begin
         r = lfsr(r);
         @(posedge clk);
         otp_load <= 1'b1;
         {otp_up, otp_lim, otp_dbl, otp_sgl} <= r[4:0];
         otp_down <= i[1:0];
         @(posedge clk);
         otp_load <= 1'b0;
         #1;
         check("up_freq", up_f, r[4]);
         check("down_freq", down_f, i[1:0]);
         check("limit", lim_f, r[3:2]);
         rd(`LDCR_OFF_FREQ, {5'h00, r[4], i[1:0]});
         rd(`LDCR_OFF_CORR_STAT, {6'h00, r[1:0]});
      end
      // Read-only places ignore writes; inverted data shows any leak
      ldcr_host_inst.wr(`LDCR_OFF_FREQ, {5'h1F, ~r[4], 2'h0});
      ldcr_host_inst.wr(`LDCR_OFF_CORR_STAT, {6'h3F, ~r[1:0]});
      ldcr_host_inst.wr(`LDCR_OFF_LOAD_HIGH, 8'hFF);
      rd(`LDCR_OFF_FREQ, {5'h1F, r[4], 2'h3});
      rd(`LDCR_OFF_CORR_STAT, {6'h00, r[1:0]});
      rd(`LDCR_OFF_LOAD_HIGH, 8'h00);
      // Every current-limit code
      for (int i = 0; i < 4; i++) begin
         ldcr_host_inst.wr(`LDCR_OFF_ILIM, {6'h00, i[1:0]});
         #1;
         check("limit", lim_f, i[1:0]);
         rd(`LDCR_OFF_ILIM, {6'h00, i[1:0]});
      end
      // Measurement for every select value, result read back whole
      for (int i = 0; i < 4; i++) begin
         r = lfsr(r);
         @(posedge clk);
         sel_wr    <= 1'b1;
         sel_value <= i[1:0];
         @(posedge clk);
         sel_wr <= 1'b0;
         #1;
         check("meas_start", meas_start, 1'b1);
         check("meas_conv", meas_conv, i[0]);
         @(posedge clk);
         meas_done  <= 1'b1;
         meas_value <= r[8:0];
         #1;
         check("meas_start", meas_start, 1'b0);
         @(posedge clk);
         meas_done  <= 1'b0;
         meas_value <= ~r[8:0];  // Must not reach the readout
         rd(`LDCR_OFF_LOAD_HIGH, {7'h00, r[8]});
         rd(`LDCR_OFF_LOAD_LOW, r[7:0]);
      end
      // Unlock, permit, then re-lock by a stray code write
      ldcr_host_inst.unlock();
      settle();
      check("lock_flag", lock_flag, 1'b0);
      rd(`LDCR_OFF_GUARD_CODE, 8'h00);
      permit_write(1'b1);
      check("permit", permit, 1'b1);
      // The last code is used: a leading code would open a new sequence
      ldcr_host_inst.wr(`LDCR_OFF_GUARD_CODE, `LDCR_CODE_THIRD);
      settle();
      check("lock_flag", lock_flag, 1'b1);
      permit_write(1'b0);
      check("permit", permit, 1'b1);
      // Re-lock by the watchdog lock write
      ldcr_host_inst.unlock();
      settle();
      check("lock_flag", lock_flag, 1'b0);
      @(posedge clk);
      wd_set <= 1'b1;
      @(posedge clk);
      wd_set <= 1'b0;
      settle();
      check("lock_flag", lock_flag, 1'b1);
      // A wrong code in mid-sequence restarts it
      ldcr_host_inst.wr(`LDCR_OFF_GUARD_CODE, `LDCR_CODE_FIRST);
      ldcr_host_inst.wr(`LDCR_OFF_GUARD_CODE, 8'h00);
      ldcr_host_inst.wr(`LDCR_OFF_GUARD_CODE, `LDCR_CODE_SECOND);
      ldcr_host_inst.wr(`LDCR_OFF_GUARD_CODE, `LDCR_CODE_THIRD);
      settle();
      check("lock_flag", lock_flag, 1'b1);
      // Sequence ignored while the watchdog lock bit is set
      wd_bit <= 1'b1;
      ldcr_host_inst.unlock();
      settle();
      check("lock_flag", lock_flag, 1'b1);
      wd_bit <= 1'b0;
      ldcr_host_inst.unlock();
      permit_write(1'b0);
      check("permit", permit, 1'b0);
      // Bounded drain of outstanding reads
      for (int k = 0; k < 20 && exp_q.size() != 0; k++)
         @(posedge clk);
      if (exp_q.size() != 0)
         mismatches++;
      finish_test();
   end
endmodule : load_current_freq_wd_unlock_regs_bench
`default_nettype wire
